// ---- common/serial_port_pkg.sv ----
// Constants, field layouts and state types for the framed asynchronous serial port
package serial_port_pkg;

  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFF      = 8'h00;
  localparam logic [ADDR_W-1:0] BUF_OFF       = 8'h04;
  localparam logic [ADDR_W-1:0] POWER_OFF     = 8'h08;
  localparam logic [ADDR_W-1:0] CONVERTER_OFF = 8'h0C;
  localparam logic [ADDR_W-1:0] RELOAD_OFF    = 8'h10;

  // Field positions
  localparam int BAUD_DOUBLER_BIT = 7;
  localparam int BRG_SELECT_BIT   = 7;

  // Modes
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_1     = 2'h1;
  localparam logic [1:0] MODE_2     = 2'h2;
  localparam logic [1:0] MODE_3     = 2'h3;

  // Reset values and counter marks
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [9:0] RELOAD_RESET  = 10'h3D9;
  localparam logic [9:0] BRG_TOP       = 10'h3FF;
  localparam logic [3:0] DIV_LAST      = 4'hF;
  localparam logic [3:0] DIV_ZERO      = 4'h0;
  localparam logic [3:0] SAMPLE_FIRST  = 4'h7;
  localparam logic [3:0] SAMPLE_SECOND = 4'h8;
  localparam logic [3:0] SAMPLE_THIRD  = 4'h9;
  localparam logic [8:0] RX_FILL       = 9'h1FF;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Serial control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] mode;
    logic       multiprocessor_filter_enable;
    logic       receive_enable;
    logic       transmit_ninth_bit;
    logic       received_ninth_bit;
    logic       transmit_done_flag;
    logic       receive_done_flag;
  } serial_ctrl_s;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA} tx_state_e;
  typedef enum logic [1:0] {RX_HUNT, RX_BITS, RX_TAIL} rx_state_e;

endpackage : serial_port_pkg

// ---- logic/async_serial_port.sv ----
// Framed asynchronous serial port, modes 1 to 3, with an AXI4-Lite register slave
`timescale 1ns/1ns
module async_serial_port (
  input  wire logic                                  ref_clk,
  input  wire logic                                  rst_b,
  input  wire logic [serial_port_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                                  s_axi_awvalid,
  output      logic                                  s_axi_awready,
  input  wire logic [31:0]                           s_axi_wdata,
  input  wire logic [3:0]                            s_axi_wstrb,
  input  wire logic                                  s_axi_wvalid,
  output      logic                                  s_axi_wready,
  output      logic [1:0]                            s_axi_bresp,
  output      logic                                  s_axi_bvalid,
  input  wire logic                                  s_axi_bready,
  input  wire logic [serial_port_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                                  s_axi_arvalid,
  output      logic                                  s_axi_arready,
  output      logic [31:0]                           s_axi_rdata,
  output      logic [1:0]                            s_axi_rresp,
  output      logic                                  s_axi_rvalid,
  input  wire logic                                  s_axi_rready,
  input  wire logic                                  timer1_overflow,
  input  wire logic                                  serial_in_line,
  output      logic                                  serial_out_line,
  output      logic                                  transmit_active
);
  import serial_port_pkg::*;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    reg_hit = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction : reg_hit

  // ==========================================================================
  // Register bus slave
  logic                aw_hold_r;
  logic [ADDR_W-1:0]   aw_addr_r;
  logic                w_hold_r;
  logic [31:0]         w_data_r;
  logic [3:0]          w_strb_r;
  logic                bvalid_r;
  logic [1:0]          bresp_r;
  logic                rvalid_r;
  logic [31:0]         rdata_r;
  logic [1:0]          rresp_r;
  logic                wr_fire;
  logic                rd_fire;
  logic                wr_mapped;
  logic                wr_ctrl;
  logic                wr_buf;
  logic                wr_power;
  logic                wr_conv;
  logic                wr_reload;
  logic [31:0]         rd_word;
  logic                rd_mapped;

  serial_ctrl_s        ctrl_r;
  serial_ctrl_s        ctrl_nxt;
  logic [7:0]          power_r;
  logic [7:0]          conv_r;
  logic [9:0]          reload_r;
  logic [7:0]          rx_buf_r;

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  assign wr_fire   = aw_hold_r && w_hold_r && !bvalid_r;
  assign rd_fire   = s_axi_arvalid && !rvalid_r;
  assign wr_ctrl   = wr_fire && reg_hit(aw_addr_r, CTRL_OFF) && w_strb_r[0];
  assign wr_buf    = wr_fire && reg_hit(aw_addr_r, BUF_OFF) && w_strb_r[0];
  assign wr_power  = wr_fire && reg_hit(aw_addr_r, POWER_OFF) && w_strb_r[0];
  assign wr_conv   = wr_fire && reg_hit(aw_addr_r, CONVERTER_OFF) && w_strb_r[0];
  assign wr_reload = wr_fire && reg_hit(aw_addr_r, RELOAD_OFF) && (w_strb_r[0] || w_strb_r[1]);
  assign wr_mapped = reg_hit(aw_addr_r, CTRL_OFF) || reg_hit(aw_addr_r, BUF_OFF)
                  || reg_hit(aw_addr_r, POWER_OFF) || reg_hit(aw_addr_r, CONVERTER_OFF)
                  || reg_hit(aw_addr_r, RELOAD_OFF);

  always_comb begin
    rd_word   = 32'h0000_0000;
    rd_mapped = 1'b1;
    if (reg_hit(s_axi_araddr, CTRL_OFF)) begin
      rd_word[7:0] = ctrl_r;
    end else if (reg_hit(s_axi_araddr, BUF_OFF)) begin
      rd_word[7:0] = rx_buf_r;
    end else if (reg_hit(s_axi_araddr, POWER_OFF)) begin
      rd_word[7:0] = power_r;
    end else if (reg_hit(s_axi_araddr, CONVERTER_OFF)) begin
      rd_word[7:0] = conv_r;
    end else if (reg_hit(s_axi_araddr, RELOAD_OFF)) begin
      rd_word[9:0] = reload_r;
    end else begin
      rd_mapped = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_hold_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      power_r  <= 8'h00;
      conv_r   <= 8'h00;
      reload_r <= RELOAD_RESET;
    end else begin
      if (wr_power) begin
        power_r <= w_data_r[7:0];
      end
      if (wr_conv) begin
        conv_r <= w_data_r[7:0];
      end
      if (wr_reload && w_strb_r[0]) begin
        reload_r[7:0] <= w_data_r[7:0];
      end
      if (wr_reload && w_strb_r[1]) begin
        reload_r[9:8] <= w_data_r[9:8];
      end
    end
  end

  // ==========================================================================
  // Bit clock: sixteen sample ticks per bit time
  logic       baud_doubler;
  logic       use_generator;
  logic [9:0] brg_cnt_r;
  logic       brg_overflow;
  logic       rate_source;
  logic       half_r;
  logic       sample_tick;
  logic       mode_framed;

  assign baud_doubler  = power_r[BAUD_DOUBLER_BIT];
  assign use_generator = conv_r[BRG_SELECT_BIT];
  assign mode_framed   = (ctrl_r.mode != MODE_SHIFT);
  assign brg_overflow  = (brg_cnt_r == BRG_TOP);
  // Mode 2 counts the core clock; modes 1 and 3 count the chosen overflow
  assign rate_source   = (ctrl_r.mode == MODE_2) ? 1'b1
                       : (use_generator ? brg_overflow : timer1_overflow);
  // Halving unless doubled: 2^doubler/32 of the source per bit
  assign sample_tick   = rate_source && (baud_doubler || half_r);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      brg_cnt_r <= RELOAD_RESET;
      half_r    <= 1'b0;
    end else begin
      if (wr_reload || brg_overflow) begin
        brg_cnt_r <= reload_r;
      end else begin
        brg_cnt_r <= brg_cnt_r + 10'h001;
      end
      if (rate_source) begin
        half_r <= !half_r;
      end
    end
  end

  // ==========================================================================
  // Transmitter
  tx_state_e  tx_state_r;
  logic [8:0] tx_shift_r;
  logic [3:0] tx_div_r;
  logic       tx_req_r;
  logic       tx_first_r;
  logic       tx_roll;
  logic       tx_end;
  logic       tx_fill;
  logic       tx_done_set;

  assign tx_roll     = sample_tick && (tx_div_r == DIV_LAST);
  // Marker or stop bit sits just left of the last bit shown, never before the first shift
  assign tx_end      = !tx_first_r && (tx_shift_r[8:1] == 8'h01);
  assign tx_fill     = (ctrl_r.mode != MODE_1) && tx_first_r;
  assign tx_done_set = tx_roll && (tx_state_r == TX_DATA) && tx_end;

  assign transmit_active = (tx_state_r != TX_IDLE);
  assign serial_out_line = (tx_state_r == TX_START) ? 1'b0
                         : (tx_state_r == TX_DATA) ? tx_shift_r[0] : 1'b1;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_div_r <= DIV_ZERO;
    end else if (sample_tick) begin
      tx_div_r <= tx_div_r + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state_r <= TX_IDLE;
      tx_shift_r <= 9'h000;
      tx_req_r   <= 1'b0;
      tx_first_r <= 1'b0;
    end else begin
      if (wr_buf && mode_framed && !transmit_active) begin
        tx_shift_r <= {(ctrl_r.mode == MODE_1) ? 1'b1 : ctrl_r.transmit_ninth_bit,
                       w_data_r[7:0]};
        tx_req_r   <= 1'b1;
      end else if (tx_roll) begin
        case (tx_state_r)
          TX_IDLE: begin
            if (tx_req_r) begin
              tx_state_r <= TX_START;
              tx_req_r   <= 1'b0;
            end
          end
          TX_START: begin
            tx_state_r <= TX_DATA;
            tx_first_r <= 1'b1;
          end
          TX_DATA: begin
            tx_shift_r <= {tx_fill, tx_shift_r[8:1]};
            tx_first_r <= 1'b0;
            if (tx_end) begin
              tx_state_r <= TX_IDLE;
            end
          end
          default: begin
            tx_state_r <= TX_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Receiver
  rx_state_e  rx_state_r;
  logic [8:0] rx_shift_r;
  logic [3:0] rx_div_r;
  logic       rx_prev_r;
  logic       rx_first_r;
  logic       samp_a_r;
  logic       samp_b_r;
  logic       rx_vote;
  logic       vote_ev;
  logic       start_det;
  logic       rx_final;
  logic       rx_load;

  assign start_det = sample_tick && (rx_state_r == RX_HUNT) && ctrl_r.receive_enable
                  && mode_framed && rx_prev_r && !serial_in_line;
  assign vote_ev   = sample_tick && (rx_state_r != RX_HUNT) && (rx_div_r == SAMPLE_THIRD);
  assign rx_vote   = (samp_a_r & samp_b_r) | (samp_a_r & serial_in_line)
                   | (samp_b_r & serial_in_line);
  // Start bit reached the far end: this vote is the last shift
  assign rx_final  = vote_ev && (rx_state_r == RX_BITS) && !rx_first_r && !rx_shift_r[0];
  assign rx_load   = rx_final && !ctrl_r.receive_done_flag
                  && (!ctrl_r.multiprocessor_filter_enable || rx_vote);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_prev_r <= 1'b1;
      samp_a_r  <= 1'b1;
      samp_b_r  <= 1'b1;
    end else if (sample_tick) begin
      rx_prev_r <= serial_in_line;
      if (rx_div_r == SAMPLE_FIRST) begin
        samp_a_r <= serial_in_line;
      end
      if (rx_div_r == SAMPLE_SECOND) begin
        samp_b_r <= serial_in_line;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state_r <= RX_HUNT;
      rx_shift_r <= RX_FILL;
      rx_div_r   <= DIV_ZERO;
      rx_first_r <= 1'b0;
    end else if (start_det) begin
      rx_state_r <= RX_BITS;
      rx_div_r   <= DIV_ZERO;
      rx_shift_r <= RX_FILL;
      rx_first_r <= 1'b1;
    end else if (sample_tick) begin
      rx_div_r <= rx_div_r + 4'h1;
      if (vote_ev) begin
        case (rx_state_r)
          RX_BITS: begin
            rx_first_r <= 1'b0;
            if (rx_first_r && rx_vote) begin
              rx_state_r <= RX_HUNT;
            end else begin
              rx_shift_r <= {rx_vote, rx_shift_r[8:1]};
              if (rx_final) begin
                rx_state_r <= (ctrl_r.mode == MODE_1) ? RX_HUNT : RX_TAIL;
              end
            end
          end
          RX_TAIL: begin
            rx_state_r <= RX_HUNT;
          end
          default: begin
            rx_state_r <= RX_HUNT;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_buf_r <= 8'h00;
    end else if (rx_load) begin
      rx_buf_r <= rx_shift_r[8:1];
    end
  end

  // ==========================================================================
  // Control register: hardware sets win over a software write
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = serial_ctrl_s'(w_data_r[7:0]);
    end
    if (rx_load) begin
      ctrl_nxt.received_ninth_bit = rx_vote;
      ctrl_nxt.receive_done_flag  = 1'b1;
    end
    if (tx_done_set) begin
      ctrl_nxt.transmit_done_flag = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= serial_ctrl_s'(CTRL_RESET);
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ==========================================================================
  // Checks
  property p_start_low;
    @(posedge ref_clk) disable iff (!rst_b)
    (tx_state_r == TX_START) |-> !serial_out_line;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_begin_on_roll;
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(transmit_active) |-> $past(tx_roll) && $past(tx_req_r);
  endproperty
  a_begin_on_roll: assert property (p_begin_on_roll) else $error("send began off rollover");

  property p_marker_load;
    @(posedge ref_clk) disable iff (!rst_b)
    (wr_buf && !transmit_active && ctrl_r.mode == MODE_1) |=> tx_shift_r[8] && tx_req_r;
  endproperty
  a_marker_load: assert property (p_marker_load) else $error("marker not loaded");

  property p_ninth_load;
    @(posedge ref_clk) disable iff (!rst_b)
    (wr_buf && !transmit_active && ctrl_r.mode[1])
      |=> tx_shift_r[8] == $past(ctrl_r.transmit_ninth_bit);
  endproperty
  a_ninth_load: assert property (p_ninth_load) else $error("ninth bit not loaded");

  property p_done_at_end;
    @(posedge ref_clk) disable iff (!rst_b)
    $fell(transmit_active) |-> ctrl_r.transmit_done_flag && serial_out_line;
  endproperty
  a_done_at_end: assert property (p_done_at_end) else $error("send ended without done flag");

  property p_start_reset;
    @(posedge ref_clk) disable iff (!rst_b)
    start_det |=> (rx_div_r == DIV_ZERO) && (rx_shift_r == RX_FILL) && (rx_state_r == RX_BITS);
  endproperty
  a_start_reset: assert property (p_start_reset) else $error("receiver not reset on start");

  property p_false_start;
    @(posedge ref_clk) disable iff (!rst_b)
    (vote_ev && rx_first_r && rx_vote) |=> (rx_state_r == RX_HUNT);
  endproperty
  a_false_start: assert property (p_false_start) else $error("false start accepted");

  property p_gate_load;
    @(posedge ref_clk) disable iff (!rst_b)
    (rx_final && ctrl_r.receive_done_flag && !wr_ctrl) |=> $stable(rx_buf_r) && ctrl_r.receive_done_flag;
  endproperty
  a_gate_load: assert property (p_gate_load) else $error("buffer loaded while flag set");

  property p_flag_hold;
    @(posedge ref_clk) disable iff (!rst_b)
    (ctrl_r.transmit_done_flag && !wr_ctrl) |=> ctrl_r.transmit_done_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("done flag dropped by itself");

  property p_mode2_rate;
    @(posedge ref_clk) disable iff (!rst_b)
    (ctrl_r.mode == MODE_2 && baud_doubler && $past(ctrl_r.mode == MODE_2)) |-> sample_tick;
  endproperty
  a_mode2_rate: assert property (p_mode2_rate) else $error("mode 2 doubled rate wrong");

  property p_tail_wait;
    @(posedge ref_clk) disable iff (!rst_b)
    (rx_final && ctrl_r.mode[1]) |=> (rx_state_r == RX_TAIL);
  endproperty
  a_tail_wait: assert property (p_tail_wait) else $error("no stop bit wait");

endmodule : async_serial_port

// ---- tb/remote_serial_node.sv ----
// Remote serial node: drives frames into the port and captures frames it sends
`timescale 1ns/1ns
module remote_serial_node (
  input  wire logic ref_clk,
  input  wire logic serial_out_line,
  output      logic serial_in_line,
  input  wire logic eleven
);
  logic [9:0] rx_q[$];
  initial serial_in_line = 1'b1;
  task automatic send(input logic [7:0] d, input logic n9, input logic st);
    logic [10:0] f;
    f = {st, n9, d, 1'b0};
    @(posedge ref_clk);
    for (int i = 0; i < (eleven ? 11 : 10); i++) begin
      serial_in_line <= f[i];
      repeat (16) @(posedge ref_clk);
    end
    // Line returns to idle high even after a low stop bit
    serial_in_line <= 1'b1;
  endtask : send
  // Short low pulse that a majority vote must reject
  task automatic glitch();
    @(posedge ref_clk);
    serial_in_line <= 1'b0;
    repeat (4) @(posedge ref_clk);
    serial_in_line <= 1'b1;
    repeat (40) @(posedge ref_clk);
  endtask : glitch
  always @(negedge serial_out_line) begin : cap
    logic [9:0] w;
    w = '1;
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < (eleven ? 10 : 9); i++) begin
      repeat (16) @(posedge ref_clk);
      w[i] = serial_out_line;
    end
    rx_q.push_back(w);
  end
endmodule : remote_serial_node

// ---- tb/tb_top.sv ----
// Self-checking bench for the framed asynchronous serial port
`timescale 1ns/1ns
module tb_top;
  import serial_port_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic serial_in_line, serial_out_line, transmit_active, eleven;
  logic t1_ovf = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int miscompares = 0, n_tests = 0, act_n = 0;
  always #4 ref_clk = ~ref_clk;
  async_serial_port dut (.ref_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .timer1_overflow(t1_ovf), .serial_in_line, .serial_out_line, .transmit_active);
  remote_serial_node node (.ref_clk, .serial_out_line, .serial_in_line, .eleven);
  always @(posedge ref_clk) if (transmit_active === 1'b1) act_n++;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge ref_clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      @(posedge ref_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid | s_axi_wvalid);
    do @(negedge ref_clk); while (s_axi_bvalid !== 1'b1);
    chk("write resp", s_axi_bresp, RESP_OKAY);
    @(posedge ref_clk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge ref_clk); while (s_axi_arready !== 1'b1);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge ref_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge ref_clk);
    s_axi_rready <= 1'b0;
  endtask : rd
  // Sends one byte with receiver off and counts the cycles the frame keeps the sender busy
  task automatic tx_time(input logic [1:0] m, input logic [7:0] d, input int exp);
    act_n = 0;
    wr(CTRL_OFF, {24'h0, m, 6'h00});
    wr(BUF_OFF, {24'h0, d});
    while (transmit_active !== 1'b0 || act_n == 0) @(negedge ref_clk);
    chk("tx rate cycles", act_n, exp);
  endtask : tx_time
  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    print_verdict();
  end
  initial begin
    logic [31:0] v, d;
    logic [1:0] r, m;
    logic [7:0] eb;
    logic t8, n9, erb, eri;
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    eleven = 1'b0;
    eb = '0;
    void'($urandom(82039));
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(CTRL_OFF, v, r);
    chk("ctrl reset", v, 32'h0);
    rd(RELOAD_OFF, v, r);
    chk("reload reset", v, 32'h3D9);
    rd(8'h40, v, r);
    chk("unmapped resp", r, RESP_SLVERR);
    wr(POWER_OFF, 32'h80);
    for (int i = 1; i < 4; i++) begin
      m = i[1:0];
      eleven = (m != MODE_1);
      d = $urandom;
      t8 = $urandom;
      act_n = 0;
      wr(CTRL_OFF, {24'h0, m, 2'b01, t8, 3'b000});
      wr(BUF_OFF, {24'h0, d[7:0]});
      while (transmit_active !== 1'b0 || act_n == 0) @(negedge ref_clk);
      chk("tx active cycles", act_n, eleven ? 160 : 144);
      repeat (16) @(posedge ref_clk);
      chk("tx frame", node.rx_q.pop_front(), {1'b1, eleven ? t8 : 1'b1, d[7:0]});
      rd(CTRL_OFF, v, r);
      chk("tx done flag", v, {24'h0, m, 2'b01, t8, 3'b010});
      wr(CTRL_OFF, {24'h0, m, 2'b11, t8, 3'b000});
      erb = 1'b0;
      eri = 1'b0;
      node.glitch();
      for (int k = 0; k < 4; k++) begin
        d = $urandom;
        n9 = (k != 2);
        if (k == 2) begin
          wr(CTRL_OFF, {24'h0, m, 2'b11, t8, erb, 2'b00});
          eri = 1'b0;
        end
        node.send(d[7:0], n9, k != 3);
        repeat (32) @(posedge ref_clk);
        if (!eri && n9) begin
          eb = d[7:0];
          erb = n9;
          eri = 1'b1;
        end
        rd(BUF_OFF, v, r);
        chk("rx buffer", v, {24'h0, eb});
        rd(CTRL_OFF, v, r);
        chk("rx ctrl", v, {24'h0, m, 2'b11, t8, erb, 1'b0, eri});
      end
      $display("mode %0d test done", m);
    end
    // Mode 2 undoubled: 32 cycles per bit, start plus nine bits; byte makes the stop check look done early
    wr(POWER_OFF, 32'h00);
    tx_time(MODE_2, 8'h02, 320);
    // Mode 1 from the internal generator, two-cycle overflow, doubled: 32 cycles per bit
    wr(POWER_OFF, 32'h80);
    wr(CONVERTER_OFF, 32'h80);
    wr(RELOAD_OFF, 32'h3FE);
    t1_ovf <= 1'b0;
    tx_time(MODE_1, 8'($urandom), 288);
    $display("rate test done");
    print_verdict();
  end
endmodule : tb_top
